// ==== design/pao_pkg.sv ====
// Constants shared by the converter output port design.
// Assumes a 100 MHz system clock and a sampled conversion clock pin.
package pao_pkg;

  localparam int unsigned WORD_W          = 14;
  localparam int unsigned PIPE_LATENCY    = 13;
  localparam int unsigned TRIM_CYCLES     = 272800;
  localparam int unsigned FLUSH_CYCLES    = 13;
  localparam int unsigned SAMPLE_IN_W     = 16;
  localparam logic [13:0] CODE_NEG_FULL   = 14'h2000;
  localparam logic [13:0] CODE_POS_FULL   = 14'h1fff;
  localparam logic [13:0] WORD_RESET      = 14'h0000;
  localparam logic [4:0]  PIN_RESET       = 5'h02; // Sync reset: read enable idle high
  localparam int unsigned CNT_W           = 20;

  typedef enum logic [1:0] {
    PAO_ST_RESET = 2'b00,
    PAO_ST_FLUSH = 2'b01,
    PAO_ST_RUN   = 2'b11,
    PAO_ST_TRIM  = 2'b10
  } pao_state_t;

endpackage

// ==== design/pao_sync.sv ====
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs come from outside the system clock domain.
`timescale 1ns/10ps
`default_nettype none
module pao_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two stages; first stage feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule
`default_nettype wire

// ==== design/pao_top.sv ====
// Digital output port of a pipelined converter: sample, pipeline, drive.
// Assumes conversion clock and controls arrive as pins; sample data is
// presented by the analog front end as a wide signed value on i_sample_raw.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Output word is 14-bit signed
// - Positive input gives positive code
// - Below range saturates to most negative
// - Above range saturates to most positive
// - One output word per conversion clock
// - Sample captured on conversion clock fall
// - Result appears thirteen cycles after sample
// - Words undefined during reset or trim
// - Drive data only while read enable low
// - Sleep low stops conversion, low power
// - Trim ends after fixed clock count
// - Thirteen words after reset/trim discarded
// - Valid strobe low when data valid
module pao_top #(
  parameter int unsigned TRIM_COUNT  = pao_pkg::TRIM_CYCLES,
  parameter int unsigned LATENCY     = pao_pkg::PIPE_LATENCY
) (
  input  wire logic                             i_sys_clk,
  input  wire logic                             i_rst_n,
  input  wire logic                             i_conv_clk,
  input  wire logic                             i_conv_reset,
  input  wire logic                             i_trim_req,
  input  wire logic                             i_read_en_n,
  input  wire logic                             i_sleep_n,
  input  wire logic signed [pao_pkg::SAMPLE_IN_W-1:0] i_sample_raw,
  output logic             [pao_pkg::WORD_W-1:0]      o_sample_word_out,
  output logic             [pao_pkg::WORD_W-1:0]      o_sample_word_oe,
  output logic                                  o_word_valid_n,
  output logic                                  o_trim_busy
);

  localparam int unsigned W  = pao_pkg::WORD_W;
  localparam int unsigned SW = pao_pkg::SAMPLE_IN_W;
  localparam int unsigned CW = pao_pkg::CNT_W;

  // Synchronised control pins
  logic [4:0] pins_s;
  logic       clk_s;
  logic       rst_s;
  logic       trim_s;
  logic       rd_n_s;
  logic       sleep_n_s;

  // Read enable resets to its idle high level so the bus stays off until the
  // pin is seen; sleep resets low so the mode logic waits in reset meanwhile
  pao_sync #(
    .W       (5),
    .RST_VAL (pao_pkg::PIN_RESET)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_conv_clk, i_conv_reset, i_trim_req, i_read_en_n, i_sleep_n}),
    .o_sync    (pins_s)
  );

  assign {clk_s, rst_s, trim_s, rd_n_s, sleep_n_s} = pins_s;

  // State registers
  logic                         clk_prev_q;
  logic                         clk_prev_d;
  logic                         trim_prev_q;
  logic                         trim_prev_d;
  pao_pkg::pao_state_t          st_q;
  pao_pkg::pao_state_t          st_d;
  logic [pao_pkg::CNT_W-1:0]    cnt_q;
  logic [pao_pkg::CNT_W-1:0]    cnt_d;
  logic [W-1:0]                 pipe_q [LATENCY];
  logic [W-1:0]                 pipe_d [LATENCY];
  logic [LATENCY-1:0]           vld_q;
  logic [LATENCY-1:0]           vld_d;
  logic [W-1:0]                 word_q;
  logic [W-1:0]                 word_d;
  logic [W-1:0]                 oe_q;
  logic [W-1:0]                 oe_d;
  logic                         valid_n_q;
  logic                         valid_n_d;
  logic                         busy_q;
  logic                         busy_d;

  // Combinational helpers
  logic                         fall;
  logic                         trim_rise;
  logic                         running;
  logic                         running_nx;
  logic [W-1:0]                 sat_word;

  // Edge detectors and mode decode
  assign fall       = clk_prev_q & ~clk_s;
  assign trim_rise  = trim_s & ~trim_prev_q;
  assign running    = (st_q == pao_pkg::PAO_ST_RUN) || (st_q == pao_pkg::PAO_ST_FLUSH);
  assign running_nx = (st_d == pao_pkg::PAO_ST_RUN) || (st_d == pao_pkg::PAO_ST_FLUSH);

  // Saturating conversion of the front-end value to signed 14 bits
  always_comb begin
    if (i_sample_raw < $signed({{(SW-W+1){1'b1}}, {(W-1){1'b0}}})) begin
      sat_word = pao_pkg::CODE_NEG_FULL;
    end else if (i_sample_raw > $signed({{(SW-W+1){1'b0}}, {(W-1){1'b1}}})) begin
      sat_word = pao_pkg::CODE_POS_FULL;
    end else begin
      sat_word = i_sample_raw[W-1:0];
    end
  end

  // Mode sequencing: reset, flush, run; trim returns to flush
  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    clk_prev_d  = clk_s;
    trim_prev_d = trim_s;
    if (!sleep_n_s || rst_s) begin
      st_d  = pao_pkg::PAO_ST_RESET;
      cnt_d = '0;
    end else begin
      unique case (st_q)
        pao_pkg::PAO_ST_RESET: begin
          st_d  = pao_pkg::PAO_ST_FLUSH;
          cnt_d = '0;
        end
        pao_pkg::PAO_ST_FLUSH: begin
          if (trim_rise) begin
            st_d  = pao_pkg::PAO_ST_TRIM;
            cnt_d = '0;
          end else if (fall) begin
            if (cnt_q == CW'(pao_pkg::FLUSH_CYCLES - 1)) begin
              st_d = pao_pkg::PAO_ST_RUN;
            end else begin
              cnt_d = cnt_q + CW'(1);
            end
          end
        end
        pao_pkg::PAO_ST_RUN: begin
          if (trim_rise) begin
            st_d  = pao_pkg::PAO_ST_TRIM;
            cnt_d = '0;
          end
        end
        pao_pkg::PAO_ST_TRIM: begin
          if (fall) begin
            if (cnt_q == CW'(TRIM_COUNT - 1)) begin
              st_d  = pao_pkg::PAO_ST_FLUSH;
              cnt_d = '0;
            end else begin
              cnt_d = cnt_q + CW'(1);
            end
          end
        end
      endcase
    end
  end

  // Sample pipeline and output drive
  always_comb begin
    pipe_d    = pipe_q;
    vld_d     = vld_q;
    word_d    = word_q;
    valid_n_d = valid_n_q;
    busy_d    = (st_d == pao_pkg::PAO_ST_TRIM);
    oe_d      = rd_n_s ? '0 : '1;
    if (fall && running) begin
      pipe_d[0] = sat_word;
      vld_d[0]  = (st_q == pao_pkg::PAO_ST_RUN) || (st_q == pao_pkg::PAO_ST_FLUSH);
      for (int i = 1; i < LATENCY; i++) begin
        pipe_d[i] = pipe_q[i-1];
        vld_d[i]  = vld_q[i-1];
      end
      word_d    = pipe_q[LATENCY-1];
      valid_n_d = ~vld_q[LATENCY-1];
    end
    // Leaving run or flush: drop valids at once so strobe never overlaps busy
    if (!running_nx) begin
      vld_d     = '0;
      valid_n_d = 1'b1;
    end
  end

  // Register update
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_prev_q  <= 1'b0;
      trim_prev_q <= 1'b0;
      st_q        <= pao_pkg::PAO_ST_RESET;
      cnt_q       <= '0;
      vld_q       <= '0;
      word_q      <= pao_pkg::WORD_RESET;
      oe_q        <= '0;
      valid_n_q   <= 1'b1;
      busy_q      <= 1'b0;
      for (int i = 0; i < LATENCY; i++) begin
        pipe_q[i] <= pao_pkg::WORD_RESET;
      end
    end else begin
      clk_prev_q  <= clk_prev_d;
      trim_prev_q <= trim_prev_d;
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      vld_q       <= vld_d;
      word_q      <= word_d;
      oe_q        <= oe_d;
      valid_n_q   <= valid_n_d;
      busy_q      <= busy_d;
      pipe_q      <= pipe_d;
    end
  end

  // Ports straight from flops
  assign o_sample_word_out = word_q;
  assign o_sample_word_oe  = oe_q;
  assign o_word_valid_n    = valid_n_q;
  assign o_trim_busy       = busy_q;

endmodule
`default_nettype wire

// ==== tb/pao_host_model.sv ====
// Host side model: free-running conversion clock source.
// Assumes a 100 MHz system clock.
`timescale 1ns/10ps
`default_nettype none
module pao_host_model #(
  parameter int unsigned HALF = 20
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  output logic      o_conv_clk,
  output logic      o_rise
);
  logic [5:0] cnt_q;
  // 2.5 MHz clock, even duty, strobe on each rise
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q      <= 6'h00;
      o_conv_clk <= 1'b0;
      o_rise     <= 1'b0;
    end else begin
      cnt_q      <= (cnt_q == 6'(2 * HALF - 1)) ? 6'h00 : cnt_q + 6'h01;
      o_conv_clk <= (cnt_q < 6'(HALF));
      o_rise     <= (cnt_q == 6'h00);
    end
  end
endmodule
`default_nettype wire

// ==== tb/pao_top_assertions.sv ====
// Port checker for the converter output port.
// Assumes it is bound into pao_top.
`timescale 1ns/10ps
`default_nettype none
module pao_chk #(
  parameter int unsigned TRIM_COUNT = 20,
  parameter int unsigned LATENCY    = 13
) (
  input wire logic               i_sys_clk,
  input wire logic               i_rst_n,
  input wire logic               i_conv_clk,
  input wire logic               i_conv_reset,
  input wire logic               i_trim_req,
  input wire logic               i_read_en_n,
  input wire logic               i_sleep_n,
  input wire logic signed [15:0] i_sample_raw,
  input wire logic        [13:0] o_sample_word_out,
  input wire logic        [13:0] o_sample_word_oe,
  input wire logic               o_word_valid_n,
  input wire logic               o_trim_busy
);
  // All checks on the system clock
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  oe_on_a: assert property (!i_read_en_n [*4] |-> &o_sample_word_oe) else $error("bus not driven");
  oe_off_a: assert property (i_read_en_n [*4] |-> o_sample_word_oe == 14'h0000) else $error("bus driven");
  oe_whole_a: assert property (o_sample_word_oe == 14'h0000 || &o_sample_word_oe) else $error("split enable");
  sleep_inv_a: assert property (!i_sleep_n [*4] |-> o_word_valid_n) else $error("valid in sleep");
  reset_inv_a: assert property (i_conv_reset [*4] |-> o_word_valid_n) else $error("valid in reset");
  trim_inv_a: assert property (o_trim_busy |-> o_word_valid_n) else $error("valid in trim");
  trim_end_a: assert property ($rose(o_trim_busy) |-> ##[1:1000] !o_trim_busy) else $error("trim hangs");
  word_hold_a: assert property ($stable({i_conv_clk, i_conv_reset, i_sleep_n, i_trim_req}) [*6]
    |-> $stable(o_sample_word_out)) else $error("word moved without fall");
  // Main scenarios reached
  cover property ($fell(o_word_valid_n));
  cover property ($rose(o_trim_busy));
  cover property (i_read_en_n [*4]);
endmodule
bind pao_top pao_chk #(.TRIM_COUNT(TRIM_COUNT), .LATENCY(LATENCY)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_conv_clk(i_conv_clk), .i_conv_reset(i_conv_reset),
  .i_trim_req(i_trim_req), .i_read_en_n(i_read_en_n), .i_sleep_n(i_sleep_n), .i_sample_raw(i_sample_raw),
  .o_sample_word_out(o_sample_word_out), .o_sample_word_oe(o_sample_word_oe),
  .o_word_valid_n(o_word_valid_n), .o_trim_busy(o_trim_busy));
`default_nettype wire

// ==== tb/pao_top_bench.sv ====
// Self-checking bench for the converter output port.
// Assumes the host model supplies the conversion clock.
`timescale 1ns/10ps
`default_nettype none
module pao_top_bench;
  typedef struct {logic [15:0] s; logic [13:0] e;} pao_row_t;
  logic clk = 0, rst_n = 0, creset = 1, trim = 0, rd_n = 1, sleep_n = 1, conv, rise, vld_n, busy;
  logic signed [15:0] smp = 16'h0000;
  logic [13:0] word, oe;
  int error_cnt = 0, compares = 0, n = 0;
  // Sample in, expected code out
  pao_row_t rows [9] = '{'{16'h0000, 14'h0000}, '{16'h0001, 14'h0001}, '{16'hffff, 14'h3fff},
    '{16'h1fff, 14'h1fff}, '{16'h2000, 14'h1fff}, '{16'h7fff, 14'h1fff}, '{16'he000, 14'h2000},
    '{16'hdfff, 14'h2000}, '{16'h8000, 14'h2000}};
  always #5 clk = ~clk;
  pao_host_model u_host (.i_sys_clk(clk), .i_rst_n(rst_n), .o_conv_clk(conv), .o_rise(rise));
  pao_top #(.TRIM_COUNT(20)) u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_conv_clk(conv),
    .i_conv_reset(creset), .i_trim_req(trim), .i_read_en_n(rd_n), .i_sleep_n(sleep_n), .i_sample_raw(smp),
    .o_sample_word_out(word), .o_sample_word_oe(oe), .o_word_valid_n(vld_n), .o_trim_busy(busy));
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_rise();
    int k;
    @(posedge clk);
    for (k = 0; k < 99 && !rise; k++) @(posedge clk);
    if (!rise) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // Stream table rows, then awkward cases
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) wait_rise();
    creset <= 1'b0;
    rd_n   <= 1'b0;
    for (int i = 0; i < 45; i++) begin
      wait_rise();
      smp <= rows[i % 9].s;
      check(14'(vld_n), (i >= 13) ? 14'h0000 : 14'h0001);
      if (i >= 14 && vld_n === 1'b0) begin
        n++;
        check(word, rows[(i - 14) % 9].e);
      end
    end
    check(14'(n > 9), 14'h0001);
    rd_n <= 1'b1;
    repeat (5) @(posedge clk);
    check(oe, 14'h0000);
    rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    check(oe, 14'h3fff);
    sleep_n <= 1'b0;
    repeat (2) wait_rise();
    check(14'(vld_n), 14'h0001);
    sleep_n <= 1'b1;
    repeat (30) wait_rise();
    check(14'(vld_n), 14'h0000);
    trim <= 1'b1;
    repeat (2) wait_rise();
    trim <= 1'b0;
    check(14'({busy, vld_n}), 14'h0003);
    for (n = 0; n < 2000 && busy; n++) @(posedge clk);
    check(14'(busy), 14'h0000);
    for (int j = 0; j < 12; j++) begin
      wait_rise();
      check(14'(vld_n), 14'h0001);
    end
    creset <= 1'b1;
    repeat (2) wait_rise();
    check(14'(vld_n), 14'h0001);
    // System reset while conversion reset is held, reads held off: outputs idle, bus stays off
    rst_n <= 1'b0;
    rd_n  <= 1'b1;
    @(posedge clk);
    check(word, 14'h0000);
    check(14'({busy, vld_n}), 14'h0001);
    rst_n <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      check(oe, 14'h0000);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
